// >>> rtl/adc_seq_defines.svh
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

// ----------------------------------------
// register offsets and reset values
// ----------------------------------------
`define ADDR_MODE 8'h00
`define ADDR_RESULT 8'h04
`define MODE_RESET 8'h00
`define RESULT_RESET 16'h0000
`define RDATA_NONE 16'h0000

// ----------------------------------------
// mode control field positions
// ----------------------------------------
`define BIT_RUN 7
`define BIT_ZERO 6
`define CLKSEL_LSB 3
`define MODESEL_LSB 1
`define BIT_CMP_EN 0
`define RESULT_PAD 6

// ----------------------------------------
// conversion clock divisors, select 0..7
// ----------------------------------------
`define DIV_SEL0 7'h40
`define DIV_SEL1 7'h20
`define DIV_SEL2 7'h10
`define DIV_SEL3 7'h08
`define DIV_SEL4 7'h06
`define DIV_SEL5 7'h05
`define DIV_SEL6 7'h04
`define DIV_SEL7 7'h02

// ----------------------------------------
// max start delay in system clocks
// ----------------------------------------
`define SDLY_SEL0 6'h3f
`define SDLY_SEL1 6'h1f
`define SDLY_SEL2 6'h0f
`define SDLY_SEL3 6'h07
`define SDLY_SEL4 6'h05
`define SDLY_SEL5 6'h04
`define SDLY_SEL6 6'h03
`define SDLY_SEL7 6'h01
`define SDLY_WAIT 6'h01

// ----------------------------------------
// conversion lengths in conversion clocks
// ----------------------------------------
`define CONV_CYC_M0 6'h13
`define SAMP_CYC_M0 6'h07
`define CONV_CYC_M1 6'h11
`define SAMP_CYC_M1 6'h05
`define RES8_SHORT 6'h02
`define STAB_FAD 6'h08

`endif

// >>> rtl/adc_seq_pkg.sv
package adc_seq_pkg;

	typedef enum logic [1:0] {
		TRIG_SW = 2'b00,
		TRIG_HW_NOWAIT = 2'b10,
		TRIG_HW_WAIT = 2'b11
	} trig_mode_e;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_TRIG = 3'b001,
		ST_DELAY = 3'b010,
		ST_STAB = 3'b011,
		ST_CONV = 3'b100
	} seq_state_e;

	typedef struct packed {
		logic conversion_run_flag;
		logic bit6_zero;
		logic [2:0] conv_clock_select;
		logic [1:0] conv_mode_select;
		logic comparator_enable;
	} mode_reg_s;

	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;

	typedef struct packed {
		logic comparator_enable;
		logic sample;
		logic active;
	} core_ctrl_s;

endpackage : adc_seq_pkg

// >>> rtl/cycle_counter.sv
`timescale 1ns/1ps
module cycle_counter #(
	parameter int W = 6
) (
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_load,
	input wire logic [W-1:0] i_value,
	input wire logic i_step,
	output logic [W-1:0] o_count,
	output logic o_zero
);
	logic [W-1:0] count_q;

	// load wins over a step in the same cycle
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset)
			count_q <= '0;
		else if (i_load)
			count_q <= i_value;
		else if (i_step && count_q != '0)
			count_q <= count_q - 1'b1;
	end

	assign o_count = count_q;
	assign o_zero = (count_q == '0);
endmodule : cycle_counter

// >>> rtl/conv_clock_divider.sv
`timescale 1ns/1ps
`include "adc_seq_defines.svh"
module conv_clock_divider (
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_restart,
	input wire logic [2:0] i_sel,
	output logic o_tick
);
	logic [5:0] cnt_q;
	logic [6:0] div;
	logic [5:0] last;

	always_comb begin
		unique case (i_sel)
			3'h0: div = `DIV_SEL0;
			3'h1: div = `DIV_SEL1;
			3'h2: div = `DIV_SEL2;
			3'h3: div = `DIV_SEL3;
			3'h4: div = `DIV_SEL4;
			3'h5: div = `DIV_SEL5;
			3'h6: div = `DIV_SEL6;
			3'h7: div = `DIV_SEL7;
		endcase
	end

	assign last = 6'(div - 7'h01);
	// not gated by restart: the restart itself depends on this tick
	assign o_tick = (cnt_q == last);

	// restart realigns the phase so a conversion starts on a full period
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset)
			cnt_q <= '0;
		else if (i_restart || cnt_q == last)
			cnt_q <= '0;
		else
			cnt_q <= cnt_q + 6'h01;
	end
endmodule : conv_clock_divider

// >>> rtl/adc_conversion_sequencer.sv
// How it works
// - run and enable pick stop, standby, convert
// - software/no-wait: run set by write only
// - one-shot software/wait: run self-clears at end
// - one-shot no-wait: run stays set
// - wait mode: trigger sets run
// - start delay bounded per divider setting
// - sequential repeats skip delay and stabilization
// - select divides system clock 64 to 2
// - mode zero 19 clocks, mode one 17
// - eight-bit result two clocks shorter
// - start delay only before first conversion
// - done pulse at every conversion end
// - result in upper ten bits, low zero
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "adc_seq_defines.svh"
module adc_conversion_sequencer
	import adc_seq_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire reg_req_s i_req,
	output logic [15:0] o_rdata,
	input wire trig_mode_e i_trig_mode,
	input wire logic i_one_shot,
	input wire logic i_res8,
	input wire logic i_hw_trigger,
	input wire logic [9:0] i_core_data,
	output core_ctrl_s o_core,
	output logic o_conversion_done_irq
);
	// ----------------------------------------
	// register state
	// ----------------------------------------
	logic run_q, run_d;
	logic cmp_en_q;
	logic [2:0] clk_sel_q;
	logic [1:0] mode_sel_q;
	logic [15:0] result_q;
	logic [15:0] rdata_q, rdata_d;
	logic irq_q;
	core_ctrl_s core_q, core_d;
	seq_state_e st_q, st_d;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	mode_reg_s wmode;
	mode_reg_s rmode;
	wire wr_mode = i_req.wr && (i_req.addr == `ADDR_MODE);
	wire rd_mode = i_req.rd && (i_req.addr == `ADDR_MODE);
	wire rd_result = i_req.rd && (i_req.addr == `ADDR_RESULT);
	assign wmode = mode_reg_s'(i_req.wdata[7:0]);

	always_comb begin
		rmode = mode_reg_s'(`MODE_RESET);
		rmode.conversion_run_flag = run_q;
		rmode.conv_clock_select = clk_sel_q;
		rmode.conv_mode_select = mode_sel_q;
		rmode.comparator_enable = cmp_en_q;
	end

	assign rdata_d = rd_mode ? {8'h00, rmode} :
		rd_result ? result_q : `RDATA_NONE;

	// ----------------------------------------
	// run flag set and clear
	// ----------------------------------------
	wire conv_ok = run_q && cmp_en_q;
	wire is_wait = (i_trig_mode == TRIG_HW_WAIT);
	wire fad;
	wire dly_zero;
	wire conv_zero;
	wire [5:0] conv_cnt;
	wire done = (st_q == ST_CONV) && fad && conv_zero && conv_ok;

	// trigger only counts from standby in wait mode
	wire trig_set = (st_q == ST_IDLE) && is_wait && cmp_en_q && !run_q
		&& i_hw_trigger;
	// a write of one in wait mode is dropped, zero returns to standby
	wire sw_run = is_wait ? (run_q && wmode.conversion_run_flag)
		: wmode.conversion_run_flag;
	wire auto_clr = done && i_one_shot
		&& (i_trig_mode != TRIG_HW_NOWAIT);

	// hardware set beats a software clear in the same cycle
	assign run_d = trig_set ? 1'b1 : wr_mode ? sw_run :
		auto_clr ? 1'b0 : run_q;

	// ----------------------------------------
	// timing figures from the selections
	// ----------------------------------------
	logic [5:0] sdly;
	always_comb begin
		unique case (clk_sel_q)
			3'h0: sdly = `SDLY_SEL0;
			3'h1: sdly = `SDLY_SEL1;
			3'h2: sdly = `SDLY_SEL2;
			3'h3: sdly = `SDLY_SEL3;
			3'h4: sdly = `SDLY_SEL4;
			3'h5: sdly = `SDLY_SEL5;
			3'h6: sdly = `SDLY_SEL6;
			3'h7: sdly = `SDLY_SEL7;
		endcase
	end

	// low-voltage codes share the counts of the normal codes
	wire [5:0] conv_base = mode_sel_q[0] ? `CONV_CYC_M1 : `CONV_CYC_M0;
	wire [5:0] samp_len = mode_sel_q[0] ? `SAMP_CYC_M1 : `SAMP_CYC_M0;
	wire [5:0] conv_len = i_res8 ? 6'(conv_base - `RES8_SHORT)
		: conv_base;
	wire [5:0] conv_last = 6'(conv_len - 6'h01);
	wire [5:0] samp_edge = 6'(conv_last - samp_len);
	// idle and delay states together take sdly clocks
	wire sdly_direct = (sdly == 6'h01);
	wire [5:0] sdly_load = 6'(sdly - 6'h02);

	// ----------------------------------------
	// sequence control
	// ----------------------------------------
	logic [5:0] start_st;
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			ST_IDLE: begin
				if (trig_set)
					st_d = ST_STAB;
				else if (conv_ok && i_trig_mode == TRIG_HW_NOWAIT)
					st_d = ST_TRIG;
				else if (conv_ok && i_trig_mode == TRIG_SW)
					st_d = sdly_direct ? ST_CONV : ST_DELAY;
			end
			ST_TRIG: begin
				if (i_hw_trigger)
					st_d = sdly_direct ? ST_CONV : ST_DELAY;
			end
			ST_DELAY: begin
				if (dly_zero)
					st_d = ST_CONV;
			end
			ST_STAB: begin
				if (fad && dly_zero)
					st_d = ST_CONV;
			end
			ST_CONV: begin
				if (done && i_one_shot)
					st_d = (i_trig_mode == TRIG_HW_NOWAIT) ?
						ST_TRIG : ST_IDLE;
			end
			default: st_d = ST_IDLE;
		endcase
		// a cleared run or enable stops any phase at once
		if (!conv_ok && st_q != ST_IDLE && !trig_set)
			st_d = ST_IDLE;
	end

	// repeats go straight back into conversion
	wire conv_enter = (st_d == ST_CONV) && ((st_q != ST_CONV)
		|| done);
	wire stab_enter = (st_d == ST_STAB) && (st_q != ST_STAB);
	wire dly_enter = (st_d == ST_DELAY) && (st_q != ST_DELAY);
	assign start_st = stab_enter ? 6'(`STAB_FAD - 6'h01) : sdly_load;

	// ----------------------------------------
	// counters and divider
	// ----------------------------------------
	conv_clock_divider u_div (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_restart(conv_enter || stab_enter),
		.i_sel(clk_sel_q),
		.o_tick(fad)
	);

	cycle_counter #(.W(6)) u_dly (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_load(dly_enter || stab_enter),
		.i_value(start_st),
		.i_step((st_q == ST_DELAY) || fad),
		.o_count(),
		.o_zero(dly_zero)
	);

	cycle_counter #(.W(6)) u_conv (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_load(conv_enter),
		.i_value(conv_last),
		.i_step(fad),
		.o_count(conv_cnt),
		.o_zero(conv_zero)
	);

	// ----------------------------------------
	// core controls
	// ----------------------------------------
	always_comb begin
		core_d.comparator_enable = cmp_en_q;
		core_d.active = (st_q == ST_CONV);
		core_d.sample = (st_q == ST_CONV) && (conv_cnt > samp_edge);
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			run_q <= 1'b0;
			cmp_en_q <= 1'b0;
			clk_sel_q <= 3'h0;
			mode_sel_q <= 2'h0;
		end else begin
			run_q <= run_d;
			// bit six is never stored so it always reads zero
			if (wr_mode) begin
				cmp_en_q <= wmode.comparator_enable;
				clk_sel_q <= wmode.conv_clock_select;
				mode_sel_q <= wmode.conv_mode_select;
			end
		end
	end

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			st_q <= ST_IDLE;
			result_q <= `RESULT_RESET;
			irq_q <= 1'b0;
			rdata_q <= `RDATA_NONE;
			core_q <= '0;
		end else begin
			st_q <= st_d;
			if (done)
				result_q <= {i_core_data, `RESULT_PAD'h00};
			irq_q <= done;
			rdata_q <= rdata_d;
			core_q <= core_d;
		end
	end

	assign o_rdata = rdata_q;
	assign o_conversion_done_irq = irq_q;
	assign o_core = core_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_reset);

	sequence s_irq_pulse;
		o_conversion_done_irq ##1 !o_conversion_done_irq;
	endsequence

	sequence s_fad_quiet;
		!fad [*8];
	endsequence

	a_stop_goes_idle: assert property (
		(!conv_ok && !trig_set) |=> (st_q == ST_IDLE))
		else $error("sequencer active without run and enable");

	a_sw_write_sets: assert property (
		(wr_mode && wmode.conversion_run_flag && !is_wait)
		|=> run_q)
		else $error("software write of one did not set run");

	a_oneshot_clears: assert property (
		(done && i_one_shot && i_trig_mode != TRIG_HW_NOWAIT
		&& !wr_mode && !trig_set) |=> !run_q)
		else $error("one-shot end did not clear run");

	a_nowait_keeps: assert property (
		(done && i_one_shot && i_trig_mode == TRIG_HW_NOWAIT
		&& !wr_mode) |=> (run_q && st_q == ST_TRIG))
		else $error("no-wait one-shot lost run");

	a_wait_trig_run: assert property (
		trig_set |=> (run_q && st_q == ST_STAB))
		else $error("wait trigger did not start");

	a_delay_bound: assert property (
		(st_q == ST_DELAY) |-> ##[0:62] (st_q != ST_DELAY))
		else $error("start delay too long");

	a_seq_repeat: assert property (
		(done && !i_one_shot && conv_ok && !wr_mode)
		|=> (st_q == ST_CONV))
		else $error("sequential repeat took a delay");

	a_div64_period: assert property (
		(fad && clk_sel_q == 3'h0 && st_q == ST_CONV && !done)
		|=> s_fad_quiet)
		else $error("divide by 64 ticks too soon");

	a_done_irq: assert property (
		(done && !$past(done)) |=> s_irq_pulse)
		else $error("done pulse missing");

	a_result_pad: assert property (
		done |=> (result_q == {$past(i_core_data), 6'h00}))
		else $error("result word not loaded");

endmodule : adc_conversion_sequencer

// >>> verif/core_model.sv
`timescale 1ns/1ps
// --------
// analog core and trigger source
// --------
module core_model
	import adc_seq_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire core_ctrl_s i_core,
	input wire logic i_fire,
	output logic o_hw_trigger,
	output logic [9:0] o_core_data,
	output logic [9:0] o_value
);
	logic active_q;
	logic fire_q;
	// idle core shows inverted value so a stray capture is caught
	assign o_core_data = i_core.active ? o_value : ~o_value;
	// one pulse per fire edge; bench keeps fires far apart
	assign o_hw_trigger = i_fire & ~fire_q;
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			active_q <= 1'b0;
			fire_q <= 1'b0;
			o_value <= 10'h155;
		end else begin
			active_q <= i_core.active;
			fire_q <= i_fire;
			if (i_core.active & ~active_q)
				o_value <= o_value + 10'h13b;
		end
	end
endmodule : core_model

// >>> verif/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
	samples_checked++; \
	if ((g) !== (e)) begin \
		mismatches++; \
		$display("[FAIL] %s expected %0h seen %0h", nm, e, g); \
	end \
end
module testbench
	import adc_seq_pkg::*;
;
	logic i_mclk;
	logic i_reset;
	reg_req_s i_req;
	logic [15:0] o_rdata;
	trig_mode_e i_trig_mode;
	logic i_one_shot;
	logic i_res8;
	logic i_hw_trigger;
	logic fire;
	logic [9:0] i_core_data;
	logic [9:0] value;
	core_ctrl_s o_core;
	logic o_conversion_done_irq;
	int mismatches;
	int samples_checked;
	int n;
	int e;
	int k;
	int samp_n;
	logic [7:0] mode_w;
	int dv[8] = '{64, 32, 16, 8, 6, 5, 4, 2};

	adc_conversion_sequencer dut (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_req(i_req),
		.o_rdata(o_rdata),
		.i_trig_mode(i_trig_mode),
		.i_one_shot(i_one_shot),
		.i_res8(i_res8),
		.i_hw_trigger(i_hw_trigger),
		.i_core_data(i_core_data),
		.o_core(o_core),
		.o_conversion_done_irq(o_conversion_done_irq)
	);
	core_model far_side (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_core(o_core),
		.i_fire(fire),
		.o_hw_trigger(i_hw_trigger),
		.o_core_data(i_core_data),
		.o_value(value)
	);

	// --------
	// bus and helper tasks
	// --------
	task automatic final_report();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		if (a == 8'h00)
			mode_w = d;
		@(posedge i_mclk);
		i_req <= '{addr: a, wdata: {8'h00, d}, wr: 1'b1, rd: 1'b0};
		@(posedge i_mclk);
		i_req.wr <= 1'b0;
	endtask : wr

	// data must stand one cycle only, then fall back to zero
	task automatic rd_chk(input string nm, input logic [7:0] a,
		input logic [15:0] e);
		@(posedge i_mclk);
		i_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge i_mclk);
		i_req.rd <= 1'b0;
		#1;
		`CHK(nm, e, o_rdata)
		@(posedge i_mclk);
		#1;
		`CHK(nm, 16'h0000, o_rdata)
	endtask : rd_chk

	task automatic wait_irq(input int lim, input bit must, output int c);
		c = 0;
		do begin
			@(posedge i_mclk);
			#1;
			c++;
		end while (o_conversion_done_irq !== 1'b1 && c < lim);
		if (must && o_conversion_done_irq !== 1'b1) begin
			mismatches++;
			$display("[FAIL] irq expected 1 seen 0");
			final_report();
		end
	endtask : wait_irq

	// config inputs move only while stopped
	task automatic start(input trig_mode_e tm, input logic os,
		input logic r8, input logic [2:0] s, input logic [1:0] m);
		wr(8'h00, mode_w & 8'h3f);
		wr(8'h00, mode_w & 8'h3e);
		i_trig_mode <= tm;
		i_one_shot <= os;
		i_res8 <= r8;
		wr(8'h00, {2'b00, s, m, 1'b1});
		// wait mode never gets a software run write
		if (tm != TRIG_HW_WAIT) begin
			repeat (125) @(posedge i_mclk);
			wr(8'h00, {2'b10, s, m, 1'b1});
		end
	endtask : start

	task automatic pulse();
		@(posedge i_mclk);
		fire <= 1'b1;
		@(posedge i_mclk);
		fire <= 1'b0;
	endtask : pulse

	initial begin
		i_mclk = 1'b0;
		forever #4 i_mclk = ~i_mclk;
	end

	// high cycles of the sample strobe, read as differences
	always @(posedge i_mclk) begin
		if (o_core.sample === 1'b1)
			samp_n++;
	end

	// --------
	// scenarios
	// --------
	initial begin
		i_reset = 1'b1;
		i_req = '0;
		i_trig_mode = TRIG_SW;
		i_one_shot = 1'b0;
		i_res8 = 1'b0;
		fire = 1'b0;
		mismatches = 0;
		samples_checked = 0;
		mode_w = 8'h00;
		repeat (4) @(posedge i_mclk);
		i_reset <= 1'b0;
		rd_chk("mode_rst", 8'h00, 16'h0000);
		rd_chk("result_rst", 8'h04, 16'h0000);
		wr(8'h08, 8'h01);
		rd_chk("unmapped", 8'h08, 16'h0000);
		wr(8'h00, 8'h01);
		rd_chk("standby", 8'h00, 16'h0001);
		`CHK("cmp_en", 1'b1, o_core.comparator_enable)
		`CHK("idle", 1'b0, o_core.active)
		k = samp_n;
		start(TRIG_SW, 1'b1, 1'b0, 3'h7, 2'b00);
		wait_irq(200, 1, n);
		`CHK("sw_lat", 1'b1, n >= 38 && n <= 44)
		`CHK("sample", 7 * 2, samp_n - k)
		rd_chk("result", 8'h04, {value, 6'h00});
		rd_chk("auto_clr", 8'h00, 16'h0039);
		start(TRIG_SW, 1'b0, 1'b0, 3'h7, 2'b00);
		repeat (10) @(posedge i_mclk);
		wr(8'h00, 8'h39);
		wait_irq(100, 0, n);
		`CHK("abort", 1'b0, o_conversion_done_irq)
		for (int s = 0; s < 8; s++) begin
			start(TRIG_SW, 1'b0, s[1], s[2:0], {1'b0, s[0]});
			e = (19 - 2 * s[0] - 2 * s[1]) * dv[s];
			wait_irq(3000, 1, n);
			wait_irq(3000, 1, n);
			`CHK("period", e, n)
			rd_chk("seq_run", 8'h00,
				{10'h002, s[2:0], 1'b0, s[0], 1'b1});
		end
		start(TRIG_HW_NOWAIT, 1'b1, 1'b0, 3'h7, 2'b01);
		wait_irq(100, 0, n);
		`CHK("no_trig", 1'b0, o_conversion_done_irq)
		pulse();
		wait_irq(200, 1, n);
		rd_chk("nowait_run", 8'h00, 16'h00bb);
		start(TRIG_HW_WAIT, 1'b1, 1'b0, 3'h7, 2'b00);
		rd_chk("wait_standby", 8'h00, 16'h0039);
		pulse();
		rd_chk("wait_set", 8'h00, 16'h00b9);
		wait_irq(200, 1, n);
		`CHK("stab", 1'b1, n >= 48 && n <= 60)
		rd_chk("wait_clr", 8'h00, 16'h0039);
		wr(8'h00, 8'h38);
		final_report();
	end
endmodule : testbench
